// [cic_debounce.sv]
`timescale 1ns/1ns
module cic_debounce
    import cic_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic en_i,
    input  wire logic tick_i,
    input  wire logic raw_i,
    output logic      stable_o
);

    typedef struct packed {
        logic                 stable;
        logic [DEB_CNT_W-1:0] cnt;
    } cic_deb_state_t;

    cic_deb_state_t st_reg;
    cic_deb_state_t st_next;

    // Count timeout ticks while raw differs; any bounce back restarts the wait
    always_comb begin
        st_next = st_reg;
        if (raw_i == st_reg.stable) begin
            st_next.cnt = '0;
        end else if (tick_i) begin
            if (st_reg.cnt == DEBOUNCE_LAST) begin
                st_next.stable = raw_i; // R10
                st_next.cnt    = '0;
            end else begin
                st_next.cnt = st_reg.cnt + 4'h1; // R21
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else if (en_i) begin
            st_reg <= st_next;
        end
    end

    assign stable_o = st_reg.stable;

    a_deb_stable_wait: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R21
        (en_i && raw_i != st_reg.stable && !(tick_i && st_reg.cnt == DEBOUNCE_LAST))
        |=> (stable_o == $past(stable_o)))
        else $error("debounced level moved before the interval ended");

endmodule : cic_debounce

// [cic_far_model.sv]
`timescale 1ns/1ns
module cic_far_model
    import cic_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic run_i,
    output logic      timeout_clock_o
);
    logic [1:0] div_reg;

    // Timeout tick source, one tick per four clocks; parked low while disabled
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_reg <= 2'h0;
        end else if (run_i) begin
            div_reg <= div_reg + 2'h1;
        end else begin
            div_reg <= 2'h0;
        end
    end
    assign timeout_clock_o = div_reg[1];
endmodule : cic_far_model

// [cic_irq_ctrl.sv]
`timescale 1ns/1ns
// How it works
// (R1) Pins, thermal and regulator events raise requests
// (R2) Each source has a readable status bit
// (R3) Masking only blocks the request, not status
// (R4) Request is OR of unmasked status bits
// (R5) Status sticky until status register is read
// (R6) Request holds until the status read
// (R7) Present condition re-sets status after read
// (R8) Polarity bit picks rising or falling edge
// (R9) Both-edge bit triggers on either edge
// (R10) Pin inputs debounced on the timeout clock
// (R11) Host enables timeout and oscillator clocks first
// (R12) Global mask forces request off, resets set
// (R13) Request routable to any pin by function
// (R14) Status bits 15, 13, 12, 0, reset zero
// (R15) Mask bits match status positions, reset zero
// (R16) Global mask is bit 0 at 0x12
// (R17) Single-edge mode: rising normally, falling inverted
// (R18) Code 0000 level trigger, 0001 edge trigger
// (R19) Code 0011 drives the request onto pin
// (R20) New event beats a clearing read
// (R21) Debounce waits a fixed count of ticks
module cic_irq_ctrl
    import cic_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire logic              en_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    input  wire logic              thermal_alarm_i,
    input  wire logic              regulator_low_i,
    input  wire logic [1:0]        pin_level_i,
    input  wire logic [1:0]        pin_polarity_invert_i,
    input  wire logic [1:0]        pin_both_edge_select_i,
    input  wire logic [3:0]        pin1_function_code_i,
    input  wire logic [3:0]        pin2_function_code_i,
    input  wire logic              timeout_clock_i,
    input  wire logic              timeout_clock_enable_i,
    input  wire logic              oscillator_clock_enable_i,
    output logic                   irq_o,
    output logic      [1:0]        pin_irq_out_o,
    output logic      [1:0]        pin_irq_oe_o
);

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] mask;
        logic        gmask;
        logic [15:0] rdata;
        logic        irq;
        logic [1:0]  pin_out;
        logic [1:0]  pin_oe;
        logic        timeout_clock_prev;
    } cic_top_state_t;

    cic_top_state_t st_reg;
    cic_top_state_t st_next;

    logic [3:0]  pin_fn [2];
    logic [1:0]  pin_stable;
    logic [1:0]  pin_event;
    logic        timeout_clock_tick;
    logic        rd_status;
    logic [15:0] event_set;
    logic [15:0] read_clear;

    // Register address match, used by every decode below
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (addr == off);
    endfunction : reg_hit

    // Request level from a status and mask pair
    function automatic logic request_of(input logic [15:0] status,
                                        input logic [15:0] mask,
                                        input logic        gmask);
        request_of = (|(status & ~mask & LIVE_BITS)) & ~gmask; // R4 R12
    endfunction : request_of

    assign pin_fn[0] = pin1_function_code_i;
    assign pin_fn[1] = pin2_function_code_i;

    // Timeout clock is sampled; both enables must be set or debounce stalls
    assign timeout_clock_tick = timeout_clock_i & ~st_reg.timeout_clock_prev
                      & timeout_clock_enable_i & oscillator_clock_enable_i; // R11

    // One debounce and one event detector per pin
    for (genvar p = 0; p < 2; p++) begin : g_pin
        cic_debounce u_deb (
            .clock_i  (clock_i),
            .rst_b_i  (rst_b_i),
            .en_i     (en_i),
            .tick_i   (timeout_clock_tick),
            .raw_i    (pin_level_i[p]),
            .stable_o (pin_stable[p])
        ); // R10

        cic_pin_event u_evt (
            .clock_i     (clock_i),
            .rst_b_i     (rst_b_i),
            .en_i        (en_i),
            .level_i     (pin_stable[p]),
            .polarity_i  (pin_polarity_invert_i[p]),
            .both_edge_i (pin_both_edge_select_i[p]),
            .function_i  (pin_fn[p]),
            .event_o     (pin_event[p])
        );
    end

    // Gather source events into their status positions
    always_comb begin
        event_set               = '0;
        event_set[BIT_THERMAL]  = thermal_alarm_i; // R1
        event_set[BIT_REG_LOW]  = regulator_low_i; // R1
        event_set[BIT_PIN1]     = pin_event[0];
        event_set[BIT_PIN2]     = pin_event[1];
    end

    assign rd_status  = reg_rd_i & reg_hit(reg_addr_i, OFF_STATUS);
    assign read_clear = rd_status ? LIVE_BITS : 16'h0000;

    // Next state; the request is built from next values so it lines up
    always_comb begin
        st_next            = st_reg;
        st_next.timeout_clock_prev = timeout_clock_i;

        // Set wins over a read clear; mask is not consulted here
        st_next.status = ((st_reg.status & ~read_clear) | event_set) & LIVE_BITS; // R3 R5 R7 R20

        // Writes to the status register are ignored, it is read only
        if (reg_wr_i && reg_hit(reg_addr_i, OFF_MASK)) begin
            st_next.mask = reg_wdata_i & LIVE_BITS; // R15
        end
        if (reg_wr_i && reg_hit(reg_addr_i, OFF_CONFIG)) begin
            st_next.gmask = reg_wdata_i[BIT_GLOBAL]; // R16
        end

        // Readback data is captured on the read strobe and then held
        if (reg_rd_i) begin
            if (reg_hit(reg_addr_i, OFF_STATUS)) begin
                st_next.rdata = st_reg.status & LIVE_BITS; // R2 R14
            end else if (reg_hit(reg_addr_i, OFF_CONFIG)) begin
                st_next.rdata = {15'h0000, st_reg.gmask};
            end else if (reg_hit(reg_addr_i, OFF_MASK)) begin
                st_next.rdata = st_reg.mask & LIVE_BITS;
            end else begin
                st_next.rdata = 16'h0000;
            end
        end

        st_next.irq = request_of(st_next.status, st_next.mask, st_next.gmask); // R4 R6

        // Pin route: drive the request where function selects it
        for (int p = 0; p < 2; p++) begin
            st_next.pin_oe[p]  = (pin_fn[p] == FN_IRQ_OUT); // R13 R19
            st_next.pin_out[p] = st_next.irq ^ pin_polarity_invert_i[p];
        end
    end

    // Global mask starts set so nothing fires before software is ready
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg        <= '0;
            st_reg.status <= STATUS_RESET;
            st_reg.mask   <= MASK_RESET;
            st_reg.gmask  <= GLOBAL_RESET; // R12
        end else if (en_i) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o   = st_reg.rdata;
    assign irq_o         = st_reg.irq;
    assign pin_irq_out_o = st_reg.pin_out;
    assign pin_irq_oe_o  = st_reg.pin_oe;

    // Checks on the register file and request path
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    a_irq_or_mask: assert property ( // R4
        irq_o == request_of(st_reg.status, st_reg.mask, st_reg.gmask))
        else $error("request does not match unmasked status");

    a_global_mask: assert property (st_reg.gmask |-> !irq_o) // R12
        else $error("request active under global mask");

    a_status_sticky: assert property ( // R5
        (en_i && !rd_status) |=> ((st_reg.status & $past(st_reg.status)) == $past(st_reg.status)))
        else $error("status bit dropped without a read");

    a_read_clears: assert property ( // R20
        (en_i && rd_status) |=> (st_reg.status == ($past(event_set) & LIVE_BITS)))
        else $error("status after read is not the pending events");

    a_masked_sets: assert property ( // R3
        (en_i && thermal_alarm_i && st_reg.mask[BIT_THERMAL]) |=> st_reg.status[BIT_THERMAL])
        else $error("masked thermal event not reported");

    a_held_irq: assert property ( // R6
        (irq_o && !rd_status && $stable(st_reg.mask) && !reg_wr_i) |=> irq_o)
        else $error("request fell without a status read");

    a_status_read: assert property ( // R2
        (en_i && rd_status) |=> (reg_rdata_o == ($past(st_reg.status) & LIVE_BITS)))
        else $error("status readback wrong");

    a_level_pin: assert property ( // R18
        (en_i && pin_fn[0] == FN_LEVEL_IN && (pin_stable[0] ^ pin_polarity_invert_i[0]))
        |=> st_reg.status[BIT_PIN1])
        else $error("level pin did not set status");

    a_pin_route: assert property ( // R19
        en_i |=> (pin_irq_oe_o[1] == ($past(pin_fn[1]) == FN_IRQ_OUT)))
        else $error("pin route enable wrong");

    // Register writes land on the next edge; the status word ignores them.
    // A status write is dropped rather than treated as a clear, so host code cannot lose events by it.
    a_mask_write: assert property ( // R15
        (en_i && reg_wr_i && reg_hit(reg_addr_i, OFF_MASK))
        |=> (st_reg.mask == ($past(reg_wdata_i) & LIVE_BITS)))
        else $error("mask write did not land");

    a_config_write: assert property ( // R16
        (en_i && reg_wr_i && reg_hit(reg_addr_i, OFF_CONFIG))
        |=> (st_reg.gmask == $past(reg_wdata_i[BIT_GLOBAL])))
        else $error("global mask write did not land");

    a_status_readonly: assert property ( // R14
        (en_i && reg_wr_i && reg_hit(reg_addr_i, OFF_STATUS) && !rd_status && (event_set == 16'h0000))
        |=> (st_reg.status == $past(st_reg.status)))
        else $error("write altered the read-only status");

    // Readback is captured from the state before the read edge
    a_mask_read: assert property ( // R15
        (en_i && reg_rd_i && reg_hit(reg_addr_i, OFF_MASK))
        |=> (reg_rdata_o == ($past(st_reg.mask) & LIVE_BITS)))
        else $error("mask readback wrong");

    a_config_read: assert property ( // R16
        (en_i && reg_rd_i && reg_hit(reg_addr_i, OFF_CONFIG))
        |=> (reg_rdata_o == {15'h0000, $past(st_reg.gmask)}))
        else $error("global mask readback wrong");

    a_unmapped_read: assert property ( // R14
        (en_i && reg_rd_i && !reg_hit(reg_addr_i, OFF_STATUS)
         && !reg_hit(reg_addr_i, OFF_CONFIG) && !reg_hit(reg_addr_i, OFF_MASK))
        |=> (reg_rdata_o == 16'h0000))
        else $error("unmapped offset read back nonzero");

    a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) // R2
        else $error("readback changed without a read");

    a_dead_bits: assert property (((st_reg.status | st_reg.mask) & ~LIVE_BITS) == 16'h0000) // R14 R15
        else $error("unused status or mask bit set");

    // Every source sets its own bit, masked or not, and a set beats a clear
    a_thermal_sets: assert property ((en_i && thermal_alarm_i) |=> st_reg.status[BIT_THERMAL]) // R1
        else $error("thermal event not latched");

    a_reg_low_sets: assert property ((en_i && regulator_low_i) |=> st_reg.status[BIT_REG_LOW]) // R1
        else $error("regulator event not latched");

    a_pin1_sets: assert property ((en_i && pin_event[0]) |=> st_reg.status[BIT_PIN1]) // R1
        else $error("pin 1 event not latched");

    a_pin2_sets: assert property ((en_i && pin_event[1]) |=> st_reg.status[BIT_PIN2]) // R1
        else $error("pin 2 event not latched");

    a_masked_pin: assert property ( // R3
        (en_i && pin_event[0] && st_reg.mask[BIT_PIN1]) |=> st_reg.status[BIT_PIN1])
        else $error("masked pin 1 event not reported");

    a_masked_low: assert property ( // R3
        (en_i && regulator_low_i && st_reg.mask[BIT_REG_LOW]) |=> st_reg.status[BIT_REG_LOW])
        else $error("masked regulator event not reported");

    a_set_wins: assert property ( // R20
        (en_i && rd_status && thermal_alarm_i) |=> st_reg.status[BIT_THERMAL])
        else $error("clearing read swallowed a new event");

    a_condition_kept: assert property ( // R7
        (en_i && rd_status && regulator_low_i && !st_reg.mask[BIT_REG_LOW] && !st_reg.gmask && !reg_wr_i)
        |=> (st_reg.status[BIT_REG_LOW] && irq_o))
        else $error("present condition lost by the read");

    // Request follows the unmasked status in both directions
    a_irq_rises: assert property ( // R4
        (en_i && thermal_alarm_i && !st_reg.mask[BIT_THERMAL] && !st_reg.gmask && !reg_wr_i) |=> irq_o)
        else $error("unmasked event gave no request");

    a_all_masked: assert property (((st_reg.status & ~st_reg.mask) == 16'h0000) |-> !irq_o) // R3
        else $error("request from masked sources only");

    a_irq_follows: assert property ( // R4
        (!st_reg.gmask && ((st_reg.status & ~st_reg.mask) != 16'h0000)) |-> irq_o)
        else $error("unmasked status but no request");

    // Pins: ticks, routing and function codes.
    // A tick is one sampled rising edge, so a slow timeout clock cannot count twice.
    a_tick_gated: assert property ( // R11
        (!timeout_clock_enable_i || !oscillator_clock_enable_i) |-> !timeout_clock_tick)
        else $error("debounce ticked with a clock disabled");

    a_tick_single: assert property ((en_i && timeout_clock_tick) |=> !timeout_clock_tick) // R10
        else $error("one timeout edge gave two ticks");

    a_route_level: assert property ( // R13
        en_i |=> (pin_irq_out_o == ({2{irq_o}} ^ $past(pin_polarity_invert_i))))
        else $error("routed request level wrong");

    a_route_pin1: assert property ( // R19
        en_i |=> (pin_irq_oe_o[0] == ($past(pin_fn[0]) == FN_IRQ_OUT)))
        else $error("pin 1 route enable wrong");

    a_fn_other: assert property ( // R18
        ((pin_fn[0] != FN_LEVEL_IN) && (pin_fn[0] != FN_EDGE_IN)) |-> !pin_event[0])
        else $error("pin 1 event under a non-input code");

    a_pin2_level: assert property ( // R18
        (en_i && pin_fn[1] == FN_LEVEL_IN && (pin_stable[1] ^ pin_polarity_invert_i[1]))
        |=> st_reg.status[BIT_PIN2])
        else $error("level pin 2 did not set status");

    // Clock enable low freezes the whole block, reads and writes included
    a_freeze_status: assert property (!en_i |=> $stable(st_reg.status)) // R5
        else $error("status moved with the clock enable low");

    a_freeze_masks: assert property (!en_i |=> ($stable(st_reg.mask) && $stable(st_reg.gmask))) // R15
        else $error("masks moved with the clock enable low");

    a_freeze_outputs: assert property ( // R6
        !en_i |=> ($stable(irq_o) && $stable(reg_rdata_o)
                   && $stable(pin_irq_out_o) && $stable(pin_irq_oe_o)))
        else $error("outputs moved with the clock enable low");

    c_thermal_irq: cover property (en_i && thermal_alarm_i && !st_reg.gmask ##1 irq_o);
    c_set_on_read: cover property (en_i && rd_status && (event_set != 16'h0000));
    c_pin_edge: cover property (pin_event[1] && pin_fn[1] == FN_EDGE_IN);
    c_route_out: cover property (pin_irq_oe_o[0] && pin_irq_out_o[0]);
    c_level_pin: cover property (en_i && pin_event[1] && pin_fn[1] == FN_LEVEL_IN);

endmodule : cic_irq_ctrl

// [cic_pin_event.sv]
`timescale 1ns/1ns
module cic_pin_event
    import cic_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    input  wire logic       en_i,
    input  wire logic       level_i,
    input  wire logic       polarity_i,
    input  wire logic       both_edge_i,
    input  wire logic [3:0] function_i,
    output logic            event_o
);

    typedef struct packed {
        logic prev;
    } cic_evt_state_t;

    cic_evt_state_t st_reg;
    cic_evt_state_t st_next;
    logic           rise;
    logic           fall;

    // Edges are taken on the pin itself so a polarity write makes no edge
    always_comb begin
        st_next.prev = level_i;
        rise         = level_i & ~st_reg.prev;
        fall         = ~level_i & st_reg.prev;
        case (function_i)
            FN_LEVEL_IN: event_o = level_i ^ polarity_i; // R18
            FN_EDGE_IN:  event_o = both_edge_i ? (rise | fall) // R9
                                 : (polarity_i ? fall : rise); // R8 R17
            default:     event_o = 1'h0;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else if (en_i) begin
            st_reg <= st_next;
        end
    end

    a_edge_single: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R17
        (function_i == FN_EDGE_IN && !both_edge_i && (polarity_i ? rise : fall)) |-> !event_o)
        else $error("single-edge mode fired on the wrong edge");
    a_edge_both: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
        (function_i == FN_EDGE_IN && both_edge_i && (level_i != st_reg.prev)) |-> event_o)
        else $error("both-edge mode missed an edge");

endmodule : cic_pin_event

// [cic_pkg.sv]
package cic_pkg;

    // Register port geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [14:0] OFF_STATUS = 15'h0010;
    localparam logic [14:0] OFF_CONFIG = 15'h0012;
    localparam logic [14:0] OFF_MASK   = 15'h0013;

    // Field positions shared by status and mask registers, plus the global mask bit in config
    localparam int BIT_THERMAL  = 15;
    localparam int BIT_PIN2     = 13;
    localparam int BIT_PIN1     = 12;
    localparam int BIT_REG_LOW  = 0;
    localparam int BIT_GLOBAL   = 0;

    // Bits that exist in status and mask; the rest read as zero
    localparam logic [15:0] LIVE_BITS = 16'hB001;

    // Reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET   = 16'h0000;
    localparam logic        GLOBAL_RESET = 1'h1;

    // Pin function codes
    localparam logic [3:0] FN_LEVEL_IN = 4'h0;
    localparam logic [3:0] FN_EDGE_IN  = 4'h1;
    localparam logic [3:0] FN_IRQ_OUT  = 4'h3;

    // Debounce interval in timeout-clock cycles
    localparam int          DEBOUNCE_TICKS = 8;
    localparam int          DEB_CNT_W      = 4;
    localparam logic [3:0]  DEBOUNCE_LAST  = 4'(DEBOUNCE_TICKS - 1);

endpackage : cic_pkg

// [tb.sv]
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %0t %s", $time, msg); end end
module tb;
    import cic_pkg::*;
    logic              clock_i = 1'b0;
    logic              rst_b_i = 1'b0;
    logic              en      = 1'b1;
    logic [ADDR_W-1:0] addr    = 15'h0000;
    logic              wr      = 1'b0;
    logic              rd      = 1'b0;
    logic [DATA_W-1:0] wdata   = 16'h0000;
    logic [DATA_W-1:0] rdata;
    logic              therm   = 1'b0;
    logic              reglow  = 1'b0;
    logic [1:0]        lvl     = 2'h0;
    logic [1:0]        pol     = 2'h0;
    logic [1:0]        both    = 2'h0;
    logic [3:0]        fn1     = FN_EDGE_IN;
    logic [3:0]        fn2     = FN_LEVEL_IN;
    logic              timeout_clock;
    logic              timeout_clock_en = 1'b0;
    logic              osc_en   = 1'b0;
    logic              irq;
    logic [1:0]        pout;
    logic [1:0]        poe;
    int                err_total = 0;
    int                cmp_count = 0;

    always #10 clock_i = ~clock_i;

    cic_far_model far (.clock_i(clock_i), .rst_b_i(rst_b_i), .run_i(timeout_clock_en & osc_en), .timeout_clock_o(timeout_clock));

    cic_irq_ctrl dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .en_i(en), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .thermal_alarm_i(therm),
        .regulator_low_i(reglow), .pin_level_i(lvl), .pin_polarity_invert_i(pol),
        .pin_both_edge_select_i(both), .pin1_function_code_i(fn1), .pin2_function_code_i(fn2),
        .timeout_clock_i(timeout_clock), .timeout_clock_enable_i(timeout_clock_en),
        .oscillator_clock_enable_i(osc_en), .irq_o(irq), .pin_irq_out_o(pout), .pin_irq_oe_o(poe));

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc

    // Strobe held across exactly one edge; leaves the bench on a rising edge
    task automatic reg_wr(input logic [14:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : reg_wr

    // Readback is registered, so it is looked at half a cycle after the taken edge;
    // the task hands back on a rising edge so following stimulus stays on that edge
    task automatic reg_rd(input logic [14:0] a, input logic [15:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        @(negedge clock_i);
        `CHK(rdata, exp, "register readback")
        @(posedge clock_i);
    endtask : reg_rd

    task automatic irq_is(input logic exp);
        @(negedge clock_i);
        `CHK(irq, exp, "request output")
        @(posedge clock_i);
    endtask : irq_is

    task automatic report_and_stop;
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog sized at about five and a half times the expected run
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end

    initial begin
        cyc(5);
        rst_b_i <= 1'b1;
        cyc(2);
        reg_rd(OFF_CONFIG, 16'h0001);
        reg_rd(OFF_MASK, 16'h0000);
        reg_rd(OFF_STATUS, 16'h0000);
        reg_rd(15'h0011, 16'h0000);
        reg_wr(OFF_STATUS, 16'hFFFF);
        reg_rd(OFF_STATUS, 16'h0000);
        // Globally masked event still latches status
        cyc(1);
        therm <= 1'b1;
        cyc(3);
        therm <= 1'b0;
        irq_is(1'b0);
        reg_wr(OFF_CONFIG, 16'h0000);
        cyc(2);
        irq_is(1'b1);
        reg_wr(OFF_MASK, 16'h8000);
        cyc(2);
        irq_is(1'b0);
        reg_rd(OFF_MASK, 16'h8000);
        reg_rd(OFF_STATUS, 16'h8000);
        reg_rd(OFF_STATUS, 16'h0000);
        reg_wr(OFF_MASK, 16'h0000);
        // Two sources together; a condition still present survives the read
        cyc(1);
        reglow <= 1'b1;
        therm  <= 1'b1;
        cyc(2);
        therm <= 1'b0;
        reg_rd(OFF_STATUS, 16'h8001);
        reg_rd(OFF_STATUS, 16'h0001);
        cyc(1);
        irq_is(1'b1);
        reglow <= 1'b0;
        cyc(2);
        reg_rd(OFF_STATUS, 16'h0001);
        reg_rd(OFF_STATUS, 16'h0000);
        cyc(2);
        irq_is(1'b0);
        // Pin ticks need both clock enables from the host
        timeout_clock_en <= 1'b1;
        osc_en   <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            cyc(1);
            pol[0]  <= m[0];
            both[0] <= m[1];
            cyc(2);
            lvl[0] <= 1'b1;
            cyc(60);
            reg_rd(OFF_STATUS, (m[1] || !m[0]) ? 16'h1000 : 16'h0000);
            lvl[0] <= 1'b0;
            cyc(60);
            reg_rd(OFF_STATUS, (m[1] || m[0]) ? 16'h1000 : 16'h0000);
        end
        // Short glitch is swallowed; a real change waits the full interval
        lvl[0] <= 1'b1;
        cyc(12);
        lvl[0] <= 1'b0;
        cyc(60);
        reg_rd(OFF_STATUS, 16'h0000);
        lvl[0] <= 1'b1;
        cyc(16);
        reg_rd(OFF_STATUS, 16'h0000);
        cyc(50);
        reg_rd(OFF_STATUS, 16'h1000);
        // Level-coded pin keeps setting status while active
        lvl[1] <= 1'b1;
        cyc(60);
        reg_rd(OFF_STATUS, 16'h2000);
        reg_rd(OFF_STATUS, 16'h2000);
        lvl[1] <= 1'b0;
        cyc(60);
        reg_rd(OFF_STATUS, 16'h2000);
        reg_rd(OFF_STATUS, 16'h0000);
        // Request routed onto the pins, with polarity applied
        fn2    <= FN_IRQ_OUT;
        pol[1] <= 1'b1;
        therm  <= 1'b1;
        cyc(3);
        @(negedge clock_i);
        `CHK(poe, 2'b10, "pin enables")
        `CHK(pout, 2'b00, "inverted routed request")
        irq_is(1'b1);
        cyc(1);
        pol[1] <= 1'b0;
        fn1    <= FN_IRQ_OUT;
        cyc(2);
        @(negedge clock_i);
        `CHK(poe, 2'b11, "pin enables")
        `CHK(pout, 2'b10, "routed request")
        reg_wr(OFF_CONFIG, 16'h0001);
        cyc(2);
        irq_is(1'b0);
        // Clock enable low: a write to the global mask is not taken
        en <= 1'b0;
        reg_wr(OFF_CONFIG, 16'h0000);
        cyc(2);
        irq_is(1'b0);
        en <= 1'b1;
        reg_rd(OFF_CONFIG, 16'h0001);
        @(negedge clock_i);
        `CHK(pout, 2'b01, "routed request masked")
        report_and_stop();
    end
endmodule : tb
